// ---- core/encoder_output_compare_pkg.sv ----
/*
 Constants, register map and encodings for the encoder output compare block.
 Assumes an APB master on pclk and a counter value sampled on the same clock.
*/
// Function
// - Software sets a 32-bit filter length counted in counter increments.
// - Rising latch edge stores counter in temporary buffer and starts filter.
// - Latch level change before filter expiry discards the buffered value.
// - After a discard the next same-direction edge buffers anew and restarts.
// - Undisturbed filter expiry moves rising buffer into rising latch result.
// - Falling edge buffered; on expiry written to falling result, done flag set.
// - Compare against on and off thresholds; inverted when on above off.
// - Threshold compare runs only while output functions are enabled.
// - Reaching on threshold sets output, status flag and indicator.
// - Reaching off threshold clears output, status flag and indicator.
// - Manual bit true sets output, status flag and indicator.
// - Manual bit false clears output, status flag and indicator.
// - Manual bit ignored while compare enabled; applied once it is cleared.
// - Safety link uses one of eight fixed checksums or a free one.
package encoder_output_compare_pkg;
    localparam logic [11:0] ADDR_CONTROL   = 12'h000;
    localparam logic [11:0] ADDR_FILTER    = 12'h004;
    localparam logic [11:0] ADDR_ON_THRESH = 12'h008;
    localparam logic [11:0] ADDR_OFF_THRESH= 12'h00C;
    localparam logic [11:0] ADDR_STATUS    = 12'h010;
    localparam logic [11:0] ADDR_LATCH_RISE= 12'h014;
    localparam logic [11:0] ADDR_LATCH_FALL= 12'h018;
    localparam logic [11:0] ADDR_IRQ_STAT  = 12'h01C;
    localparam logic [11:0] ADDR_IRQ_MASK  = 12'h020;
    localparam logic [11:0] ADDR_SAFE_MODE = 12'h024;
    localparam logic [11:0] ADDR_SAFE_FREE = 12'h028;
    localparam logic [11:0] ADDR_SAFE_POLY = 12'h02C;

    localparam int CTRL_SET_OUTPUT   = 0;
    localparam int CTRL_ENABLE_OUTFN = 1;
    localparam int CTRL_ENABLE_MEAS  = 2;

    localparam int STAT_OUTPUT       = 0;
    localparam int STAT_MEAS_DONE    = 1;

    localparam int IRQ_RISE_LATCHED  = 0;
    localparam int IRQ_FALL_LATCHED  = 1;
    localparam int IRQ_OUT_CHANGED   = 2;
    localparam int IRQ_WIDTH         = 3;

    localparam logic [31:0] RESET_FILTER = 32'h0000_0000;
    localparam logic [31:0] RESET_WORD   = 32'h0000_0000;
    localparam logic [3:0]  SAFE_MODE_FREE = 4'h8;
    localparam logic [15:0] SAFE_FREE_PREFIX = 16'h00FF;

    localparam logic [31:0] SAFE_POLY_1 = 32'h0001_7B0F;
    localparam logic [31:0] SAFE_POLY_2 = 32'h0001_571F;
    localparam logic [31:0] SAFE_POLY_3 = 32'h0001_1F95;
    localparam logic [31:0] SAFE_POLY_4 = 32'h0001_53F1;
    localparam logic [31:0] SAFE_POLY_5 = 32'h0001_F1D5;
    localparam logic [31:0] SAFE_POLY_6 = 32'h0001_663B;
    localparam logic [31:0] SAFE_POLY_7 = 32'h0001_B8CD;
    localparam logic [31:0] SAFE_POLY_8 = 32'h0001_E1BD;

    typedef enum logic [1:0] {
        MEAS_IDLE      = 2'b00,
        MEAS_RISE_FILT = 2'b01,
        MEAS_HIGH      = 2'b10,
        MEAS_FALL_FILT = 2'b11
    } meas_state_type;
endpackage

// ---- core/latch_filter.sv ----
/*
 Filtered workpiece measurement on the external latch input.
 Assumes latch_level already synchronised and counter_value on pclk.
*/
`timescale 1ns/1ps
`default_nettype none
module latch_filter
    import encoder_output_compare_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        enable,
    input  wire logic        latch_level,
    input  wire logic [31:0] counter_value,
    input  wire logic [31:0] filter_value,
    output logic [31:0]      rise_value,
    output logic [31:0]      fall_value,
    output logic             rise_pulse,
    output logic             fall_pulse
);
    import encoder_output_compare_pkg::*;

    typedef struct packed {
        meas_state_type state;
        logic           last_level;
        logic [31:0]    held;
        logic [31:0]    start_count;
        logic [31:0]    rise_value;
        logic [31:0]    fall_value;
        logic           rise_pulse;
        logic           fall_pulse;
    } filt_state_type;

    filt_state_type cur;
    filt_state_type next_cur;
    logic [31:0]    travelled;

    always_comb begin
        next_cur = cur;
        next_cur.rise_pulse = 1'b0;
        next_cur.fall_pulse = 1'b0;
        next_cur.last_level = latch_level;
        // Distance in increments, either count direction
        travelled = (counter_value >= cur.start_count) ? counter_value - cur.start_count
                                                       : cur.start_count - counter_value;
        if (!enable) begin
            next_cur.state = MEAS_IDLE;
        end else begin
            case (cur.state)
                MEAS_IDLE: begin
                    if (latch_level && !cur.last_level) begin
                        next_cur.held = counter_value;
                        next_cur.start_count = counter_value;
                        next_cur.state = MEAS_RISE_FILT;
                    end
                end
                MEAS_RISE_FILT: begin
                    if (!latch_level) begin
                        next_cur.state = MEAS_IDLE;
                    end else if (travelled >= filter_value) begin
                        next_cur.rise_value = cur.held;
                        next_cur.rise_pulse = 1'b1;
                        next_cur.state = MEAS_HIGH;
                    end
                end
                MEAS_HIGH: begin
                    if (!latch_level && cur.last_level) begin
                        next_cur.held = counter_value;
                        next_cur.start_count = counter_value;
                        next_cur.state = MEAS_FALL_FILT;
                    end
                end
                MEAS_FALL_FILT: begin
                    if (latch_level) begin
                        next_cur.state = MEAS_HIGH;
                    end else if (travelled >= filter_value) begin
                        next_cur.fall_value = cur.held;
                        next_cur.fall_pulse = 1'b1;
                        next_cur.state = MEAS_IDLE;
                    end
                end
                default: next_cur.state = MEAS_IDLE;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cur <= '0;
        end else begin
            cur <= next_cur;
        end
    end

    assign rise_value = cur.rise_value;
    assign fall_value = cur.fall_value;
    assign rise_pulse = cur.rise_pulse;
    assign fall_pulse = cur.fall_pulse;
endmodule
`default_nettype wire

// ---- core/encoder_output_compare.sv ----
/*
 APB slave with digital output compare, manual output, filtered latch
 measurement and safety link checksum selection.
 Assumes counter_value comes from the counter core on pclk; latch_pin is
 asynchronous.
*/
// The register offsets and the APB register port were decided locally.
`timescale 1ns/1ps
`default_nettype none
module encoder_output_compare
    import encoder_output_compare_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic [31:0] counter_value,
    input  wire logic        latch_pin,
    output logic             digital_out,
    output logic             status_led,
    output logic [31:0]      safety_poly,
    output logic             safety_poly_ok,
    output logic             irq
);
    import encoder_output_compare_pkg::*;

    typedef struct packed {
        logic [1:0]     latch_sync;
        logic [2:0]     control;
        logic [31:0]    filter;
        logic [31:0]    on_thresh;
        logic [31:0]    off_thresh;
        logic           out_state;
        logic           meas_done;
        logic [IRQ_WIDTH-1:0] irq_stat;
        logic [IRQ_WIDTH-1:0] irq_mask;
        logic [3:0]     safe_mode;
        logic [31:0]    safe_free;
        logic [31:0]    prdata;
        logic           pslverr;
    } top_state_type;

    top_state_type cur;
    top_state_type next_cur;

    logic        access;
    logic        wr;
    logic [31:0] rise_value;
    logic [31:0] fall_value;
    logic        rise_pulse;
    logic        fall_pulse;
    logic        cmp_on;
    logic [31:0] poly_sel;
    logic [31:0] rd_word;
    logic        mapped;

    function automatic logic [31:0] merge_bytes(input logic [31:0] old_word,
                                                input logic [31:0] new_word,
                                                input logic [3:0]  strobes);
        logic [31:0] res;
        res = old_word;
        for (int i = 0; i < 4; i++) begin
            if (strobes[i]) begin
                res[i*8 +: 8] = new_word[i*8 +: 8];
            end
        end
        return res;
    endfunction

    // Fixed checksum table, mode 0..7; free value in modes 8..15
    function automatic logic [31:0] poly_of(input logic [3:0] mode, input logic [31:0] free);
        case (mode)
            4'h0: poly_of = SAFE_POLY_1;
            4'h1: poly_of = SAFE_POLY_2;
            4'h2: poly_of = SAFE_POLY_3;
            4'h3: poly_of = SAFE_POLY_4;
            4'h4: poly_of = SAFE_POLY_5;
            4'h5: poly_of = SAFE_POLY_6;
            4'h6: poly_of = SAFE_POLY_7;
            4'h7: poly_of = SAFE_POLY_8;
            default: poly_of = free;
        endcase
    endfunction

    latch_filter u_latch_filter (
        .pclk          (pclk),
        .presetn       (presetn),
        .enable        (cur.control[CTRL_ENABLE_MEAS]),
        .latch_level   (cur.latch_sync[1]),
        .counter_value (counter_value),
        .filter_value  (cur.filter),
        .rise_value    (rise_value),
        .fall_value    (fall_value),
        .rise_pulse    (rise_pulse),
        .fall_pulse    (fall_pulse)
    );

    assign access = psel && penable;
    assign wr     = access && pwrite;
    assign poly_sel = poly_of(cur.safe_mode, cur.safe_free);

    always_comb begin
        rd_word = 32'h0000_0000;
        mapped  = 1'b1;
        if (paddr == ADDR_CONTROL) begin
            rd_word = {29'h0, cur.control};
        end else if (paddr == ADDR_FILTER) begin
            rd_word = cur.filter;
        end else if (paddr == ADDR_ON_THRESH) begin
            rd_word = cur.on_thresh;
        end else if (paddr == ADDR_OFF_THRESH) begin
            rd_word = cur.off_thresh;
        end else if (paddr == ADDR_STATUS) begin
            rd_word = {30'h0, cur.meas_done, cur.out_state};
        end else if (paddr == ADDR_LATCH_RISE) begin
            rd_word = rise_value;
        end else if (paddr == ADDR_LATCH_FALL) begin
            rd_word = fall_value;
        end else if (paddr == ADDR_IRQ_STAT) begin
            rd_word = {29'h0, cur.irq_stat};
        end else if (paddr == ADDR_IRQ_MASK) begin
            rd_word = {29'h0, cur.irq_mask};
        end else if (paddr == ADDR_SAFE_MODE) begin
            rd_word = {28'h0, cur.safe_mode};
        end else if (paddr == ADDR_SAFE_FREE) begin
            rd_word = cur.safe_free;
        end else if (paddr == ADDR_SAFE_POLY) begin
            rd_word = poly_sel;
        end else begin
            mapped = 1'b0;
        end
    end

    always_comb begin
        next_cur = cur;
        next_cur.latch_sync = {cur.latch_sync[0], latch_pin};
        cmp_on = cur.out_state;

        if (wr && mapped) begin
            if (paddr == ADDR_CONTROL) begin
                next_cur.control = pstrb[0] ? pwdata[2:0] : cur.control;
            end else if (paddr == ADDR_FILTER) begin
                next_cur.filter = merge_bytes(cur.filter, pwdata, pstrb);
            end else if (paddr == ADDR_ON_THRESH) begin
                next_cur.on_thresh = merge_bytes(cur.on_thresh, pwdata, pstrb);
            end else if (paddr == ADDR_OFF_THRESH) begin
                next_cur.off_thresh = merge_bytes(cur.off_thresh, pwdata, pstrb);
            end else if (paddr == ADDR_IRQ_MASK) begin
                next_cur.irq_mask = pstrb[0] ? pwdata[IRQ_WIDTH-1:0] : cur.irq_mask;
            end else if (paddr == ADDR_SAFE_MODE) begin
                next_cur.safe_mode = pstrb[0] ? pwdata[3:0] : cur.safe_mode;
            end else if (paddr == ADDR_SAFE_FREE) begin
                next_cur.safe_free = merge_bytes(cur.safe_free, pwdata, pstrb);
            end
        end

        // Uses the live counter so a crossing is caught on the update that reaches it
        if (cur.control[CTRL_ENABLE_OUTFN]) begin
            if (cur.on_thresh <= cur.off_thresh) begin
                if (counter_value >= cur.off_thresh) begin
                    cmp_on = 1'b0;
                end else if (counter_value >= cur.on_thresh) begin
                    cmp_on = 1'b1;
                end
            end else begin
                // Inverted window: on above off
                if (counter_value <= cur.off_thresh) begin
                    cmp_on = 1'b0;
                end else if (counter_value >= cur.on_thresh) begin
                    cmp_on = 1'b1;
                end
            end
        end else begin
            // Manual bit only acts once compare is off
            cmp_on = cur.control[CTRL_SET_OUTPUT];
        end
        next_cur.out_state = cmp_on;

        // Disabled measurement clears done; expiry of falling filter sets it
        if (fall_pulse) begin
            next_cur.meas_done = 1'b1;
        end else if (!cur.control[CTRL_ENABLE_MEAS]) begin
            next_cur.meas_done = 1'b0;
        end

        if (wr && paddr == ADDR_IRQ_STAT && pstrb[0]) begin
            next_cur.irq_stat = cur.irq_stat & ~pwdata[IRQ_WIDTH-1:0];
        end
        // Set after clear so a same-cycle event survives
        if (rise_pulse) begin
            next_cur.irq_stat[IRQ_RISE_LATCHED] = 1'b1;
        end
        if (fall_pulse) begin
            next_cur.irq_stat[IRQ_FALL_LATCHED] = 1'b1;
        end
        if (cmp_on != cur.out_state) begin
            next_cur.irq_stat[IRQ_OUT_CHANGED] = 1'b1;
        end

        // Taken in the setup cycle: prdata comes from a flop with no wait state,
        // as the address holds through the access phase
        if (psel && !penable) begin
            next_cur.prdata  = mapped ? rd_word : 32'h0000_0000;
            next_cur.pslverr = !mapped;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cur <= '0;
        end else begin
            cur <= next_cur;
        end
    end

    // Zero wait states: unmapped addresses answer with an error
    assign pready         = 1'b1;
    assign pslverr        = access && cur.pslverr;
    assign prdata         = cur.prdata;
    assign digital_out    = cur.out_state;
    assign status_led     = cur.out_state;
    assign safety_poly    = poly_sel;
    // Free value must begin with the prefix; flagged, not enforced
    assign safety_poly_ok = (cur.safe_mode < SAFE_MODE_FREE)
                            || (cur.safe_free[31:16] == SAFE_FREE_PREFIX);
    assign irq            = |(cur.irq_stat & cur.irq_mask);
endmodule
`default_nettype wire

// ---- tb/encoder_output_compare_asserts.sv ----
/*
 Checker for the output compare block, bound to its top module.
 Assumes full-word APB writes and a counter on pclk.
*/
`timescale 1ns/1ps
`default_nettype none
module encoder_output_compare_asserts
    import encoder_output_compare_pkg::*;
(
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0]  pstrb,
    input wire logic [31:0] counter_value,
    input wire logic        digital_out,
    input wire logic        status_led,
    input wire logic [31:0] safety_poly,
    input wire logic        safety_poly_ok
);
    localparam logic [31:0] POLY_TAB [8] = '{SAFE_POLY_1, SAFE_POLY_2, SAFE_POLY_3,
        SAFE_POLY_4, SAFE_POLY_5, SAFE_POLY_6, SAFE_POLY_7, SAFE_POLY_8};
    logic [31:0] on_s, off_s, free_s;
    logic [3:0]  mode_s;
    logic        en_s, set_s, sw_on, sw_off;
    // Shadows see full-word writes only; partial writes would fool them
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            {on_s, off_s, free_s, mode_s, en_s, set_s} <= '0;
        end else if (psel && penable && pwrite && pstrb == 4'hF) begin
            case (paddr)
                ADDR_CONTROL: begin
                    en_s <= pwdata[CTRL_ENABLE_OUTFN];
                    set_s <= pwdata[CTRL_SET_OUTPUT];
                end
                ADDR_ON_THRESH:  on_s <= pwdata;
                ADDR_OFF_THRESH: off_s <= pwdata;
                ADDR_SAFE_MODE:  mode_s <= pwdata[3:0];
                ADDR_SAFE_FREE:  free_s <= pwdata;
                default: ;
            endcase
        end
    end
    always_comb begin
        sw_on = counter_value >= on_s && (on_s > off_s || counter_value < off_s);
        sw_off = on_s > off_s ? counter_value <= off_s : counter_value >= off_s;
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    AST_ON: assert property (en_s && sw_on |=> digital_out)
        else $error("output not set at switch-on value");
    AST_OFF: assert property (en_s && on_s <= off_s && sw_off |=> !digital_out)
        else $error("output not cleared at switch-off value");
    AST_INVERT: assert property (en_s && on_s > off_s && sw_off |=> !digital_out)
        else $error("inverted compare did not clear output");
    AST_HOLD: assert property (en_s && !sw_on && !sw_off |=> $stable(digital_out))
        else $error("output moved between thresholds");
    AST_MANUAL: assert property (!en_s |=> digital_out == $past(set_s))
        else $error("output does not follow manual bit");
    AST_LED: assert property (status_led == digital_out)
        else $error("indicator differs from output");
    AST_POLY: assert property (mode_s < 4'h8 |-> safety_poly == POLY_TAB[mode_s[2:0]])
        else $error("wrong fixed checksum");
    AST_FREE: assert property (mode_s >= 4'h8 |-> safety_poly == free_s &&
        safety_poly_ok == (free_s[31:16] == SAFE_FREE_PREFIX))
        else $error("wrong free checksum handling");
    cover property (en_s && on_s > off_s && sw_on);
    cover property (!en_s && set_s);
    cover property (mode_s >= 4'h8 && safety_poly_ok);
endmodule
bind encoder_output_compare encoder_output_compare_asserts i_chk (.pclk, .presetn,
    .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .counter_value, .digital_out,
    .status_led, .safety_poly, .safety_poly_ok);
`default_nettype wire

// ---- tb/apb_master_model.sv ----
/*
 Fieldbus-side master model issuing single APB transfers.
 Assumes pready comes within 16 access cycles.
*/
`timescale 1ns/1ps
`default_nettype none
module apb_master_model (
    input  wire logic   pclk,
    input  wire logic   pready,
    output logic        psel,
    output logic        penable,
    output logic        pwrite,
    output logic [11:0] paddr,
    output logic [31:0] pwdata,
    output logic [3:0]  pstrb
);
    initial begin
        {psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
    end
    // Serves one safety link, so one checksum choice
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                        output logic late);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= 4'hF;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (!pready && n < 16);
        late = !pready;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
endmodule
`default_nettype wire

// ---- tb/testbench.sv ----
/*
 Self-checking bench for the encoder output compare block.
 Assumes zero-wait APB and a counter driven by the bench.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin \
    n_tests++; \
    if ((got) !== (exp)) begin \
        miscompares++; \
        $display("wrong value at %0t: got %h expected %h", $time, got, exp); \
    end \
end
module testbench;
    import encoder_output_compare_pkg::*;
    localparam logic [31:0] FILT = 32'hA;
    localparam logic [31:0] CCNT [11] = '{32'h80, 32'h100, 32'hFF, 32'h200, 32'hFF,
        32'h100, 32'h200, 32'h150, 32'h101, 32'h100, 32'h1FF};
    localparam logic [10:0] CEXP = 11'h1C6;
    localparam logic [31:0] POLY_TAB [8] = '{SAFE_POLY_1, SAFE_POLY_2, SAFE_POLY_3,
        SAFE_POLY_4, SAFE_POLY_5, SAFE_POLY_6, SAFE_POLY_7, SAFE_POLY_8};
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, latch_pin;
    logic digital_out, status_led, safety_poly_ok, irq;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, counter_value, safety_poly, seed, c1, c2, c3;
    logic [3:0] pstrb;
    logic [32:0] e;
    logic [32:0] expq [$];
    int miscompares = 0;
    int n_tests = 0;
    encoder_output_compare i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
        .pwdata, .pstrb, .prdata, .pready, .pslverr, .counter_value, .latch_pin,
        .digital_out, .status_led, .safety_poly, .safety_poly_ok, .irq);
    apb_master_model i_master (.pclk, .pready, .psel, .penable, .pwrite, .paddr,
        .pwdata, .pstrb);
    initial begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic conclude;
        // A read whose answer never came is a miss too
        if (expq.size() != 0) miscompares++;
        $display("comparisons %0d, miscompares %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
        logic late;
        i_master.xfer(w, a, d, late);
        if (late) begin
            miscompares++;
            conclude();
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] x, input logic err = 1'b0);
        expq.push_back({err, x});
        bus(1'b0, a, 32'h0);
    endtask
    // Counter held still around edges so the sync delay cannot shift the capture
    task automatic level(input logic [31:0] v, input logic lvl);
        @(posedge pclk);
        counter_value <= v;
        latch_pin <= lvl;
        repeat (6) @(posedge pclk);
    endtask
    task automatic run(input int n);
        repeat (n) begin
            @(posedge pclk);
            counter_value <= counter_value + 32'h1;
        end
    endtask
    always @(posedge pclk) begin
        if (psel && penable && pready && !pwrite && expq.size() > 0) begin
            e = expq.pop_front();
            `CHK({pslverr, prdata}, e)
        end
    end
    initial begin
        presetn = 1'b0;
        latch_pin = 1'b0;
        counter_value = 32'h0;
        seed = 32'hB68E_B9E6;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        rd(ADDR_CONTROL, RESET_WORD);
        rd(ADDR_FILTER, RESET_FILTER);
        rd(ADDR_SAFE_POLY, SAFE_POLY_1);
        rd(12'h100, 32'h0, 1'b1);
        wr(ADDR_STATUS, 32'hFFFF_FFFF);
        rd(ADDR_STATUS, 32'h0);
        wr(ADDR_FILTER, FILT);
        rd(ADDR_FILTER, FILT);
        wr(ADDR_CONTROL, 32'h4);
        seed = lfsr(seed);
        c1 = {8'h00, seed[23:0]};
        c2 = c1 + 32'h1000;
        c3 = c2 + 32'h2000;
        level(c1, 1'b1);
        run(4);
        level(counter_value, 1'b0);
        level(c2, 1'b1);
        run(14);
        rd(ADDR_LATCH_RISE, c2);
        wr(ADDR_LATCH_RISE, 32'h0);
        rd(ADDR_LATCH_RISE, c2);
        level(c3, 1'b0);
        run(14);
        rd(ADDR_LATCH_FALL, c3);
        rd(ADDR_STATUS, 32'h2);
        rd(ADDR_IRQ_STAT, 32'h3);
        `CHK(irq, 1'b0)
        wr(ADDR_IRQ_MASK, 32'h7);
        repeat (2) @(posedge pclk);
        `CHK(irq, 1'b1)
        wr(ADDR_IRQ_STAT, 32'h3);
        repeat (2) @(posedge pclk);
        `CHK(irq, 1'b0)
        wr(ADDR_CONTROL, 32'h0);
        rd(ADDR_STATUS, 32'h0);
        wr(ADDR_CONTROL, 32'h1);
        rd(ADDR_STATUS, 32'h1);
        wr(ADDR_CONTROL, 32'h0);
        rd(ADDR_STATUS, 32'h0);
        rd(ADDR_IRQ_STAT, 32'h4);
        wr(ADDR_IRQ_STAT, 32'h4);
        wr(ADDR_ON_THRESH, 32'h100);
        wr(ADDR_OFF_THRESH, 32'h200);
        wr(ADDR_CONTROL, 32'h2);
        for (int i = 0; i < 11; i++) begin
            if (i == 5) begin
                wr(ADDR_ON_THRESH, 32'h200);
                wr(ADDR_OFF_THRESH, 32'h100);
            end
            @(posedge pclk);
            counter_value <= CCNT[i];
            rd(ADDR_STATUS, {31'h0, CEXP[i]});
        end
        wr(ADDR_CONTROL, 32'h3);
        rd(ADDR_STATUS, 32'h0);
        wr(ADDR_CONTROL, 32'h1);
        rd(ADDR_STATUS, 32'h1);
        for (int m = 0; m < 8; m++) begin
            wr(ADDR_SAFE_MODE, 32'(m));
            rd(ADDR_SAFE_POLY, POLY_TAB[m]);
            `CHK(safety_poly_ok, 1'b1)
        end
        seed = lfsr(seed);
        wr(ADDR_SAFE_FREE, {SAFE_FREE_PREFIX, seed[15:0]});
        wr(ADDR_SAFE_MODE, {28'h0, SAFE_MODE_FREE});
        rd(ADDR_SAFE_POLY, {SAFE_FREE_PREFIX, seed[15:0]});
        `CHK(safety_poly_ok, 1'b1)
        wr(ADDR_SAFE_FREE, {16'h1234, seed[15:0]});
        @(posedge pclk);
        `CHK(safety_poly_ok, 1'b0)
        repeat (2) @(posedge pclk);
        conclude();
    end
endmodule
`default_nettype wire
